// ==== tsc_thermal_regs.sv ====
// Purpose: Thermal setpoint, lock and calibration trim registers with readings
// Assumes: Single clock, synchronous active-low reset, one access per cycle
// Notes:   Read data registered one cycle after the read strobe
`timescale 1ns/1ps

module tsc_thermal_regs (
	input  wire logic               i_clock,
	input  wire logic               i_rstn,
	input  wire tsc_pkg::tsc_req_t   i_req,
	input  wire tsc_pkg::tsc_sense_t i_sense,
	input  wire logic [6:0]         i_fuse_trim,
	output logic [31:0]             o_rdata,
	output logic                    o_rd_valid,
	output logic [7:0]              o_hot_setpoint,
	output logic [7:0]              o_crit_setpoint,
	output logic [31:0]             o_aux_setpoints,
	output logic                    o_aux_lock,
	output logic                    o_crit_lock,
	output logic [7:0]              o_relative,
	output logic [8:0]              o_conv_a,
	output logic [8:0]              o_conv_b
);

	logic [7:0]  ofs_r;
	logic [7:0]  hot_r;
	logic [7:0]  crit_r;
	logic [31:0] aux_r;
	logic        aux_lock_r;
	logic [6:0]  trim_r;
	logic        crit_lock_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        rd_valid_r;
	logic [7:0]  absolute;
	logic        unlock;
	logic        wr_hc;
	logic        wr_aux;
	logic        wr_trim;
	logic        wr_ao;

	// Address match, shared by write and read decode
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	assign wr_hc   = i_req.wr && hit(i_req.addr, tsc_pkg::OFF_HOTCRIT);
	assign wr_aux  = i_req.wr && hit(i_req.addr, tsc_pkg::OFF_AUX);
	assign wr_trim = i_req.wr && hit(i_req.addr, tsc_pkg::OFF_TRIM);
	assign wr_ao   = i_req.wr && hit(i_req.addr, tsc_pkg::OFF_ABS_OFS);

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	tsc_unlock_seq u_unlock (
		.i_clock  (i_clock),
		.i_rstn   (i_rstn),
		.i_req    (i_req),
		.o_unlock (unlock)
	);

	tsc_reading u_reading (
		.i_clock    (i_clock),
		.i_rstn     (i_rstn),
		.i_sense    (i_sense),
		.i_offset   (ofs_r),
		.i_hot      (hot_r),
		.i_trim     (trim_r),
		.o_absolute (absolute),
		.o_relative (o_relative),
		.o_conv_a   (o_conv_a),
		.o_conv_b   (o_conv_b)
	);

	// ----------------------------------------------------------------
	// Setpoints and locks
	// ----------------------------------------------------------------

	// Reading offset, lane 3 of its dword
	always_ff @(posedge i_clock) begin
		if (!i_rstn) ofs_r <= tsc_pkg::RST_OFS;
		else if (wr_ao && i_req.be[tsc_pkg::LANE_OFS]) ofs_r <= i_req.wdata[31:24];
	end

	// Hot and critical setpoints; locked writes drop silently
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			hot_r  <= tsc_pkg::RST_SETPT;
			crit_r <= tsc_pkg::RST_SETPT;
		end else if (wr_hc && !crit_lock_r) begin
			if (i_req.be[tsc_pkg::HOT_LANE]) hot_r <= i_req.wdata[15:8];
			if (i_req.be[tsc_pkg::CRIT_LANE]) crit_r <= i_req.wdata[7:0];
		end
	end

	// Aux lock: a one sets it, the key sequence clears it; set wins
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			aux_lock_r <= 1'b0;
		end else if (wr_hc && i_req.be[tsc_pkg::LOCK_LANE]
			&& i_req.wdata[tsc_pkg::AUXILIARY_SETPOINT_LOCK_BIT]) begin
			aux_lock_r <= 1'b1;
		end else if (unlock) begin
			aux_lock_r <= 1'b0;
		end
	end

	// Aux setpoints, one byte lane each, gated by the aux lock
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_aux
			always_ff @(posedge i_clock) begin
				if (!i_rstn) aux_r[g*8 +: 8] <= tsc_pkg::RST_AUX[g*8 +: 8];
				else if (wr_aux && i_req.be[g] && !aux_lock_r)
					aux_r[g*8 +: 8] <= i_req.wdata[g*8 +: 8];
			end
		end
	endgenerate

	// Trim field, frozen once the critical lock is set
	always_ff @(posedge i_clock) begin
		if (!i_rstn) trim_r <= tsc_pkg::RST_TRIM;
		else if (wr_trim && i_req.be[0] && !crit_lock_r)
			trim_r <= i_req.wdata[6:0];
	end

	// Critical lock is write-one only; only reset releases it
	always_ff @(posedge i_clock) begin
		if (!i_rstn) crit_lock_r <= 1'b0;
		else if (wr_trim && i_req.be[0] && i_req.wdata[tsc_pkg::TRIM_LOCK_BIT])
			crit_lock_r <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------

	// Read mux; fuse trim comes straight from the fuses
	always_comb begin
		rdata_nxt = '0;
		if (hit(i_req.addr, tsc_pkg::OFF_ABS_OFS)) begin
			rdata_nxt = {ofs_r, absolute, 16'h0000};
		end else if (hit(i_req.addr, tsc_pkg::OFF_REL)) begin
			rdata_nxt = {24'h000000, o_relative};
		end else if (hit(i_req.addr, tsc_pkg::OFF_HOTCRIT)) begin
			rdata_nxt = {aux_lock_r, {15{1'b0}}, hot_r, crit_r};
		end else if (hit(i_req.addr, tsc_pkg::OFF_AUX)) begin
			rdata_nxt = aux_r;
		end else if (hit(i_req.addr, tsc_pkg::OFF_TRIM)) begin
			rdata_nxt = {24'h000000, crit_lock_r, trim_r};
		end else if (hit(i_req.addr, tsc_pkg::OFF_FUSE)) begin
			rdata_nxt = {{25{1'b0}}, i_fuse_trim};
		end
	end

	// Registered read answer; unmapped reads return zero
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			rdata_r    <= '0;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= i_req.rd;
			if (i_req.rd) rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_rdata         = rdata_r;
	assign o_rd_valid      = rd_valid_r;
	assign o_hot_setpoint  = hot_r;
	assign o_crit_setpoint = crit_r;
	assign o_aux_setpoints = aux_r;
	assign o_aux_lock      = aux_lock_r;
	assign o_crit_lock     = crit_lock_r; // Gates the external control bits

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	// Helpers: expected difference and zero-extended trim from what the reading block sees
	logic signed [8:0] chk_diff;
	logic [7:0]        chk_diff_lo;
	logic [8:0]        chk_trim_zx;
	assign chk_diff    = $signed({1'b0, absolute}) - $signed({1'b0, ofs_r});
	assign chk_diff_lo = chk_diff[7:0];
	assign chk_trim_zx = {2'b00, trim_r};

	// Independent sum for bank A: trim widened by its sign, plus counter
	logic [8:0]        chk_sum;
	logic              chk_live_r;
	assign chk_sum     = {{(tsc_pkg::CONV_W - tsc_pkg::TRIM_W){trim_r[tsc_pkg::TRIM_W - 1]}},
		trim_r} + {1'b0, i_sense.count};

	// Reset seen one edge late; the release edge still shows reset values,
	// so no attempt may start there
	always_ff @(posedge i_clock) chk_live_r <= i_rstn;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn || !chk_live_r);

	property p_rel_diff;
		!i_sense.analog_mode && chk_diff <= tsc_pkg::DIFF_MAX
			&& chk_diff >= tsc_pkg::DIFF_MIN |=> o_relative == $past(chk_diff_lo);
	endproperty
	a_rel_diff: assert property (p_rel_diff) else $error("relative reading wrong");

	property p_rel_clip;
		!i_sense.analog_mode && chk_diff > tsc_pkg::DIFF_MAX |=> o_relative == tsc_pkg::REL_MAX;
	endproperty
	a_rel_clip: assert property (p_rel_clip) else $error("relative reading not clipped");

	property p_rel_analog;
		i_sense.analog_mode |=> o_relative == $past(hot_r);
	endproperty
	a_rel_analog: assert property (p_rel_analog) else $error("analog mode not hot");

	property p_aux_blocked;
		aux_lock_r && wr_aux |=> $stable(aux_r);
	endproperty
	a_aux_blocked: assert property (p_aux_blocked) else $error("aux written while locked");

	property p_aux_lock_hold;
		aux_lock_r && !unlock |=> aux_lock_r;
	endproperty
	a_aux_lock_hold: assert property (p_aux_lock_hold) else $error("aux lock dropped");

	sequence s_key_seq;
		(wr_hc && i_req.wdata == tsc_pkg::UNLOCK_KEY && i_req.be == tsc_pkg::BE_ALL)
		##1 (wr_aux && i_req.wdata == tsc_pkg::UNLOCK_KEY && i_req.be == tsc_pkg::BE_ALL)
		##1 (wr_hc && i_req.wdata == tsc_pkg::UNLOCK_KEY && i_req.be == tsc_pkg::BE_ALL);
	endsequence
	property p_key_unlocks;
		s_key_seq |=> !aux_lock_r;
	endproperty
	a_key_unlocks: assert property (p_key_unlocks) else $error("key did not unlock");

	property p_aux_write;
		!aux_lock_r && wr_aux && i_req.be == tsc_pkg::BE_ALL |=> aux_r == $past(i_req.wdata);
	endproperty
	a_aux_write: assert property (p_aux_write) else $error("aux write lost");

	property p_crit_blocked;
		crit_lock_r && (wr_hc || wr_trim) |=> $stable(hot_r) && $stable(crit_r) && $stable(trim_r);
	endproperty
	a_crit_blocked: assert property (p_crit_blocked) else $error("locked field changed");

	property p_crit_sticky;
		crit_lock_r |=> crit_lock_r [*2];
	endproperty
	a_crit_sticky: assert property (p_crit_sticky) else $error("critical lock cleared");

	property p_direct_test;
		i_sense.direct_test |=> o_conv_b == $past(chk_trim_zx);
	endproperty
	a_direct_test: assert property (p_direct_test) else $error("bank B not direct");

	property p_fuse_read;
		i_req.rd && hit(i_req.addr, tsc_pkg::OFF_FUSE) |=> o_rd_valid
			&& o_rdata[6:0] == $past(i_fuse_trim);
	endproperty
	a_fuse_read: assert property (p_fuse_read) else $error("fuse readback wrong");

	property p_abs_follow;
		1'b1 |=> absolute == $past(i_sense.count);
	endproperty
	a_abs_follow: assert property (p_abs_follow) else $error("absolute reading stale");

	property p_ofs_write;
		wr_ao && i_req.be[tsc_pkg::LANE_OFS] |=> ofs_r == $past(i_req.wdata[31:24]);
	endproperty
	a_ofs_write: assert property (p_ofs_write) else $error("reading offset lost");

	property p_trim_write;
		!crit_lock_r && wr_trim && i_req.be[0] |=> trim_r == $past(i_req.wdata[6:0]);
	endproperty
	a_trim_write: assert property (p_trim_write) else $error("trim write lost");

	property p_conv_sum;
		1'b1 |=> o_conv_a == $past(chk_sum);
	endproperty
	a_conv_sum: assert property (p_conv_sum) else $error("bank A sum wrong");

	c_unlock:    cover property (s_key_seq ##1 !aux_lock_r);
	c_crit_lock: cover property (!crit_lock_r ##1 crit_lock_r);
	c_clip:      cover property (!i_sense.analog_mode && chk_diff > tsc_pkg::DIFF_MAX);
	c_direct:    cover property (i_sense.direct_test && trim_r[6]);
	c_low_clip:  cover property (!i_sense.analog_mode && chk_diff < tsc_pkg::DIFF_MIN);

endmodule

// ==== tsc_pkg.sv ====
// Purpose: Shared constants and types for the thermal setpoint and calibration registers
// Assumes: Byte addresses inside the thermal register window, dword aligned access
// Notes:   Every offset lives here; lock, converter and read-data resets and the wdata slices stay literal in the code

package tsc_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses of aligned dwords)
	// ----------------------------------------------------------------
	localparam logic [15:0] OFF_ABS_OFS = 16'h1004; // Lane 2 absolute, lane 3 offset
	localparam logic [15:0] OFF_REL     = 16'h1008;
	localparam logic [15:0] OFF_HOTCRIT = 16'h1010;
	localparam logic [15:0] OFF_AUX     = 16'h1014;
	localparam logic [15:0] OFF_TRIM    = 16'h1018;
	localparam logic [15:0] OFF_FUSE    = 16'h1030;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int unsigned LANE_ABS     = 2;
	localparam int unsigned LANE_OFS     = 3;
	localparam int unsigned AUXILIARY_SETPOINT_LOCK_BIT  = 31;
	localparam int unsigned HOT_LANE     = 1;
	localparam int unsigned CRIT_LANE    = 0;
	localparam int unsigned LOCK_LANE    = 3;
	localparam int unsigned TRIM_LOCK_BIT = 7;
	localparam int unsigned TRIM_W       = 7;
	localparam int unsigned RDG_W        = 8;
	localparam int unsigned CONV_W       = 9;

	// ----------------------------------------------------------------
	// Reset values and magic numbers
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_ABS     = 8'hff;
	localparam logic [7:0]  RST_OFS     = 8'h00;
	localparam logic [7:0]  RST_SETPT   = 8'h00;
	localparam logic [31:0] RST_AUX     = 32'h00000000;
	localparam logic [6:0]  RST_TRIM    = 7'h00;
	localparam logic [31:0] UNLOCK_KEY  = 32'h04c1c202;
	localparam logic [3:0]  BE_ALL      = 4'hf;
	localparam logic [7:0]  REL_MAX     = 8'h7f;
	localparam logic [7:0]  REL_MIN     = 8'h80;
	localparam logic signed [8:0] DIFF_MAX = 9'sh07f;
	localparam logic signed [8:0] DIFF_MIN = -9'sh080;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} tsc_req_t;

	typedef struct packed {
		logic [7:0] count;       // Live counter from the sensor
		logic       valid;       // Thermometer output valid
		logic       analog_mode; // Sensor in analog rather than thermometer mode
		logic       direct_test; // Direct converter test enable
	} tsc_sense_t;

	typedef enum logic [1:0] {US_IDLE, US_FIRST, US_SECOND} tsc_unlock_state_t;

endpackage

// ==== tsc_unlock_seq.sv ====
// Purpose: Detects the three-write key sequence that releases the auxiliary lock
// Assumes: Any other read or write in between breaks the sequence; a repeated first key write restarts it
// Notes:   Key must be written with all four byte lanes enabled
`timescale 1ns/1ps

module tsc_unlock_seq (
	input  wire logic             i_clock,
	input  wire logic             i_rstn,
	input  wire tsc_pkg::tsc_req_t i_req,
	output logic                  o_unlock
);

	tsc_pkg::tsc_unlock_state_t state_r;
	logic                       hit_first;
	logic                       hit_second;
	logic                       any_access;

	// ----------------------------------------------------------------
	// Key write detection
	// ----------------------------------------------------------------
	assign any_access = i_req.wr | i_req.rd;
	assign hit_first  = i_req.wr && i_req.be == tsc_pkg::BE_ALL
		&& i_req.addr == tsc_pkg::OFF_HOTCRIT && i_req.wdata == tsc_pkg::UNLOCK_KEY;
	assign hit_second = i_req.wr && i_req.be == tsc_pkg::BE_ALL
		&& i_req.addr == tsc_pkg::OFF_AUX && i_req.wdata == tsc_pkg::UNLOCK_KEY;
	assign o_unlock   = (state_r == tsc_pkg::US_SECOND) && hit_first;

	// Sequence tracker; a stray access restarts it
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			state_r <= tsc_pkg::US_IDLE;
		end else begin
			case (state_r)
				tsc_pkg::US_IDLE: begin
					if (hit_first) state_r <= tsc_pkg::US_FIRST;
				end
				tsc_pkg::US_FIRST: begin
					if (hit_second) state_r <= tsc_pkg::US_SECOND;
					else if (hit_first) state_r <= tsc_pkg::US_FIRST;
					else if (any_access) state_r <= tsc_pkg::US_IDLE;
				end
				tsc_pkg::US_SECOND: begin
					if (hit_first) state_r <= tsc_pkg::US_IDLE;
					else if (any_access) state_r <= tsc_pkg::US_IDLE;
				end
				default: state_r <= tsc_pkg::US_IDLE;
			endcase
		end
	end

endmodule

// ==== tsc_reading.sv ====
// Purpose: Absolute and relative readings and converter drive values
// Assumes: Counter input synchronous to i_clock
// Notes:   All outputs registered; relative lags absolute by one cycle
`timescale 1ns/1ps

module tsc_reading (
	input  wire logic               i_clock,
	input  wire logic               i_rstn,
	input  wire tsc_pkg::tsc_sense_t i_sense,
	input  wire logic [7:0]         i_offset,
	input  wire logic [7:0]         i_hot,
	input  wire logic [6:0]         i_trim,
	output logic [7:0]              o_absolute,
	output logic [7:0]              o_relative,
	output logic [8:0]              o_conv_a,
	output logic [8:0]              o_conv_b
);

	logic signed [8:0] diff;
	logic [8:0]        sum;

	// Sign-extend the seven-bit trim to converter width
	function automatic logic [8:0] sext_trim(input logic [6:0] t);
		sext_trim = {{2{t[6]}}, t};
	endfunction

	// ----------------------------------------------------------------
	// Arithmetic
	// ----------------------------------------------------------------
	assign diff = $signed({1'b0, o_absolute}) - $signed({1'b0, i_offset});
	assign sum  = sext_trim(i_trim) + {1'b0, i_sense.count};

	// Absolute reading follows the counter, all ones from reset
	always_ff @(posedge i_clock) begin
		if (!i_rstn) o_absolute <= tsc_pkg::RST_ABS;
		else o_absolute <= i_sense.count;
	end

	// Relative reading, clipped so it stays a signed byte
	always_ff @(posedge i_clock) begin
		if (!i_rstn) o_relative <= tsc_pkg::RST_OFS;
		else if (i_sense.analog_mode) o_relative <= i_hot;
		else if (diff > tsc_pkg::DIFF_MAX) o_relative <= tsc_pkg::REL_MAX;
		else if (diff < tsc_pkg::DIFF_MIN) o_relative <= tsc_pkg::REL_MIN;
		else o_relative <= diff[7:0];
	end

	// Bank A gets the sum; bank B bypasses it in direct test
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			o_conv_a <= '0;
			o_conv_b <= '0;
		end else begin
			o_conv_a <= sum;
			o_conv_b <= i_sense.direct_test ? {2'b00, i_trim} : sum;
		end
	end

endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench for the thermal setpoint and trim registers
// Assumes: Read data arrives one cycle after the read strobe
// Notes:   Expected read data is queued by the driver, checked by a monitor
`timescale 1ns/1ps

`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
	$display("Error %s expected %h seen %h", n, e, s); end end

module tb;

	// ----------------------------------------------------------------
	// Signals and bench state
	// ----------------------------------------------------------------
	logic                i_clock = 1'b0;
	logic                i_rstn  = 1'b0;
	tsc_pkg::tsc_req_t   req     = '0;
	tsc_pkg::tsc_sense_t sn      = '0;
	logic [6:0]          fuse    = 7'h00;
	logic [31:0]         rdata;
	logic                rd_valid;
	logic [7:0]          hot_o;
	logic [7:0]          crit_o;
	logic [31:0]         aux_o;
	logic                aux_lock;
	logic                crit_lock;
	logic [7:0]          rel_o;
	logic [8:0]          conv_a;
	logic [8:0]          conv_b;
	logic [31:0]         seed = 32'h0c509093;
	logic [31:0]         exq[$];
	string               nq[$];
	int                  fails = 0;
	int                  check_count = 0;

	tsc_thermal_regs u_dut (
		.i_clock         (i_clock),
		.i_rstn          (i_rstn),
		.i_req           (req),
		.i_sense         (sn),
		.i_fuse_trim     (fuse),
		.o_rdata         (rdata),
		.o_rd_valid      (rd_valid),
		.o_hot_setpoint  (hot_o),
		.o_crit_setpoint (crit_o),
		.o_aux_setpoints (aux_o),
		.o_aux_lock      (aux_lock),
		.o_crit_lock     (crit_lock),
		.o_relative      (rel_o),
		.o_conv_a        (conv_a),
		.o_conv_b        (conv_b)
	);

	// 100 ns period
	always #50 i_clock = ~i_clock;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Signed difference, clipped both ways
	function automatic logic [7:0] rel(input logic [7:0] a, input logic [7:0] o);
		int d;
		d = int'(a) - int'(o);
		if (d > 127) return 8'h7f;
		if (d < -128) return 8'h80;
		return d[7:0];
	endfunction

	// Nine-bit sum wraps like the converter input
	function automatic logic [8:0] cv(input logic [7:0] c, input logic [6:0] t);
		return {1'b0, c} + {{2{t[6]}}, t};
	endfunction

	// Idle edge after each access so strobes never merge
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge i_clock);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d, be: b};
		@(posedge i_clock);
		req <= '0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e, input string n);
		@(posedge i_clock);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0, be: 4'hf};
		exq.push_back(e);
		nq.push_back(n);
		@(posedge i_clock);
		req <= '0;
	endtask

	task automatic settle();
		repeat (3) @(posedge i_clock);
		@(negedge i_clock);
	endtask

	task automatic conclude();
		if (fails == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Read monitor: oldest note against each returned word
	// ----------------------------------------------------------------
	// Sampled mid-cycle, well clear of the edge that launches the answer
	always @(negedge i_clock) begin
		logic [31:0] mon_e;
		string       mon_n;
		if (rd_valid === 1'b1) begin
			if (exq.size() == 0) begin
				`CHK("unexpected read", 1'b0, 1'b1)
			end else begin
				mon_e = exq.pop_front();
				mon_n = nq.pop_front();
				`CHK(mon_n, mon_e, rdata)
			end
		end
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge i_clock);
		fails++;
		conclude();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0]  cnt;
		logic [7:0]  ofs;
		logic [6:0]  tr;
		logic [31:0] r;
		static logic [6:0] tl[5] = '{7'h3f, 7'h40, 7'h41, 7'h7f, 7'h00};
		repeat (5) @(posedge i_clock);
		i_rstn <= 1'b1;
		rd(16'h1010, 32'h0, "hotcrit reset");
		rd(16'h1014, 32'h0, "aux reset");
		rd(16'h1018, 32'h0, "trim reset");
		rd(16'h1020, 32'h0, "unmapped");
		// Setpoints and byte lanes
		wr(16'h1010, 32'h00005a3c, 4'hf);
		wr(16'h1014, 32'h11223344, 4'hf);
		wr(16'h1014, 32'h0000ee00, 4'h2);
		rd(16'h1010, 32'h00005a3c, "hot crit");
		rd(16'h1014, 32'h1122ee44, "aux lanes");
		// Aux lock blocks every aux byte
		wr(16'h1010, 32'h80005a3c, 4'hf);
		wr(16'h1014, 32'hffffffff, 4'hf);
		rd(16'h1014, 32'h1122ee44, "aux locked");
		// Broken key sequence: a read restarts it
		wr(16'h1010, tsc_pkg::UNLOCK_KEY, 4'hf);
		rd(16'h1010, 32'h8000c202, "key write");
		wr(16'h1014, tsc_pkg::UNLOCK_KEY, 4'hf);
		wr(16'h1010, tsc_pkg::UNLOCK_KEY, 4'hf);
		@(negedge i_clock);
		`CHK("lock held", 1'b1, aux_lock)
		wr(16'h1014, tsc_pkg::UNLOCK_KEY, 4'hf);
		wr(16'h1010, tsc_pkg::UNLOCK_KEY, 4'hf);
		@(negedge i_clock);
		`CHK("lock clear", 1'b0, aux_lock)
		`CHK("aux kept", 32'h1122ee44, aux_o)
		wr(16'h1014, 32'ha5a5a5a5, 4'hf);
		@(negedge i_clock);
		`CHK("aux live", 32'ha5a5a5a5, aux_o)
		// Lock again, then the key sequence back to back
		wr(16'h1010, 32'h8000c202, 4'hf);
		@(negedge i_clock);
		`CHK("lock set", 1'b1, aux_lock)
		@(posedge i_clock);
		req <= '{wr: 1'b1, rd: 1'b0, addr: 16'h1010, wdata: tsc_pkg::UNLOCK_KEY, be: 4'hf};
		@(posedge i_clock);
		req.addr <= 16'h1014;
		@(posedge i_clock);
		req.addr <= 16'h1010;
		@(posedge i_clock);
		req <= '0;
		@(negedge i_clock);
		`CHK("lock clear b2b", 1'b0, aux_lock)
		`CHK("aux kept b2b", 32'ha5a5a5a5, aux_o)
		// Relative reading, extremes first
		for (int i = 0; i < 12; i++) begin
			cnt = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'(xs());
			ofs = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'(xs());
			@(posedge i_clock);
			sn <= '{count: cnt, valid: 1'b1, analog_mode: 1'b0, direct_test: 1'b0};
			wr(16'h1004, {ofs, 24'h0}, 4'h8);
			settle();
			`CHK("relative", rel(cnt, ofs), rel_o)
			rd(16'h1004, {ofs, cnt, 16'h0}, "abs ofs");
			rd(16'h1008, {24'h0, rel(cnt, ofs)}, "rel reg");
		end
		@(posedge i_clock);
		sn.analog_mode <= 1'b1;
		settle();
		`CHK("analog", 8'hc2, rel_o)
		// Trim into both converter banks
		for (int i = 0; i < 10; i++) begin
			r = xs();
			tr = (i < 5) ? tl[i] : r[14:8];
			@(posedge i_clock);
			sn <= '{count: r[7:0], valid: 1'b1, analog_mode: 1'b0, direct_test: r[16]};
			fuse <= r[30:24];
			wr(16'h1018, {25'h0, tr}, 4'h1);
			settle();
			`CHK("conv a", cv(r[7:0], tr), conv_a)
			`CHK("conv b", r[16] ? {2'b00, tr} : cv(r[7:0], tr), conv_b)
			rd(16'h1018, {25'h0, tr}, "trim");
			rd(16'h1030, {25'h0, r[30:24]}, "fuse");
		end
		// Critical lock freezes hot, crit and trim
		wr(16'h1018, {24'h0, 1'b1, tr}, 4'h1);
		wr(16'h1018, 32'h00000005, 4'h1);
		wr(16'h1010, 32'h00001234, 4'hf);
		@(negedge i_clock);
		`CHK("crit lock", 1'b1, crit_lock)
		`CHK("hot frozen", 8'hc2, hot_o)
		`CHK("crit frozen", 8'h02, crit_o)
		rd(16'h1018, {24'h0, 1'b1, tr}, "trim locked");
		repeat (4) @(posedge i_clock);
		`CHK("reads pending", 0, exq.size())
		// Mid-run reset is the only way out of the critical lock
		@(posedge i_clock);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clock);
		i_rstn <= 1'b1;
		@(negedge i_clock);
		`CHK("lock after reset", 1'b0, crit_lock)
		`CHK("hot after reset", 8'h00, hot_o)
		`CHK("aux after reset", 32'h0, aux_o)
		conclude();
	end

endmodule
